// File: line_source_model.sv
// stand-in for the sampled vehicle bus lines feeding the block
// assumes the testbench sets a target level per line by calling setLine
module line_source_model
   import scope_trigger_pkg::*;
#(
   parameter int STEP = 256
) (
   input wire logic              clk,
   output level_t [NUM_LINES-1:0] lineLevels
);
   timeunit 1ns;
   timeprecision 1ps;
   int target [NUM_LINES] = '{default: 256};
   // finite slew: a level moves at most STEP per clock toward its target, passing through values between as a real line does
   function automatic logic [LEVEL_W-1:0] slew(input int cur, input int tgt);
      if (tgt > cur + STEP)
         return LEVEL_W'(cur + STEP);
      if (tgt < cur - STEP)
         return LEVEL_W'(cur - STEP);
      return LEVEL_W'(tgt);
   endfunction : slew
   always @(posedge clk)
   begin
      for (int i = 0; i < NUM_LINES; i++)
         lineLevels[i].level <= slew(lineLevels[i].level, target[i]);
   end
   task setLine(input int idx, input int lvl);
      target[idx] <= lvl;
   endtask : setLine
endmodule : line_source_model

// File: scope_trigger_capture.sv
// trace fifo and the trigger / capture controller with its APB register file
// assumes line samples arrive on clk and the display drains the trace stream
// Notes on behaviour
// - mode none captures continuously with no trigger wait
// - mode auto waits for a trigger on the selected line
// - auto forces a capture when no trigger arrives before the timeout
// - mode repeat captures only after a trigger; no trigger, no new trace
// - the trigger is judged only on the one selected line
// - rising direction starts a trace on an upward threshold crossing
// - falling direction starts a trace on a downward threshold crossing
// - the threshold level is programmable
// - trigger settings are staged; commit applies all, cancel discards staged
// - up to 32 complete waveforms are kept in the buffer
// - previous steps the display selection to the older waveform
// - next steps the display selection to the newer waveform
// - selected index and stored waveform count are readable
// - time base runs 1-2-5 from 100ns/div to 1000s/div, setting sample interval
// - time base 200ms/div or slower switches to continuous capture
// - continuous capture streams samples while the capture runs
// - a trigger edge is a crossing of the configured threshold

module trace_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wrPtr_ff;
   logic [PW-1:0] rdPtr_ff;
   logic [PW:0]   count_ff;
   logic          push;
   logic          pop;

   assign inReady  = (count_ff != (PW+1)'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem[rdPtr_ff];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_ff <= PW'(wrPtr_ff + 1'b1);
         end
         if (pop)
         begin
            rdPtr_ff <= PW'(rdPtr_ff + 1'b1);
         end
         if (push && !pop)
         begin
            count_ff <= (PW+1)'(count_ff + 1'b1);
         end
         else if (pop && !push)
         begin
            count_ff <= (PW+1)'(count_ff - 1'b1);
         end
      end
   end
endmodule : trace_fifo

module scope_trigger_capture
   import scope_trigger_pkg::*;
#(
   parameter int AUTO_TIMEOUT = AUTO_TO_CYC
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire level_t [NUM_LINES-1:0] lineLevels,
   output logic                        traceValid,
   input  wire logic                   traceReady,
   output trace_t                      traceData
);
   // ************************************************
   // declarations
   // ************************************************
   logic [LEVEL_W-1:0] waveMem [WAVE_DEPTH*REC_LEN];
   cfg_t               stage_ff;
   cfg_t               active_ff;
   logic [TB_W-1:0]    tbIdx_ff;
   logic [CYC_W-1:0]   tbCyc_ff;
   logic [CYC_W-1:0]   divCnt_ff;
   cap_state_t         state_ff;
   logic [REC_W-1:0]   capIdx_ff;
   logic [31:0]        toCnt_ff;
   logic               prevAbove_ff;
   logic               edgeValid_ff;
   logic [WAVE_W-1:0]  wrPtr_ff;
   logic [WAVE_W:0]    count_ff;
   logic [WAVE_W-1:0]  sel_ff;
   logic [REC_W-1:0]   sampSel_ff;
   logic [31:0]        prdata_ff;
   logic               pready_ff;
   logic               pslverr_ff;
   logic               setupPh;
   logic               wrAcc;
   logic               doCommit;
   logic               doCancel;
   logic               doPrev;
   logic               doNext;
   logic [31:0]        rdWord;
   logic               hit;
   logic [WAVE_W-1:0]  oldest;
   logic [WAVE_W-1:0]  physSel;
   logic [LEVEL_W-1:0] selLevel;
   logic               above;
   logic               contMode;
   logic               tickDue;
   logic               stall;
   logic               sampleTake;
   logic               trigHit;
   logic               toExpire;
   logic               capDone;
   logic               fifoInReady;
   logic [TB_W-1:0]    wrIdx;
   trace_t             pushWord;

   // ************************************************
   // APB decode
   // ************************************************
   assign setupPh  = psel & ~penable;
   assign wrAcc    = psel & penable & pready_ff & pwrite;
   assign doCommit = wrAcc && (paddr == OFF_APPLY) && pwdata[APPLY_COMMIT_BIT];
   assign doCancel = wrAcc && (paddr == OFF_APPLY) && pwdata[APPLY_CANCEL_BIT];
   assign doPrev   = wrAcc && (paddr == OFF_NAV) && pwdata[NAV_PREV_BIT];
   assign doNext   = wrAcc && (paddr == OFF_NAV) && pwdata[NAV_NEXT_BIT];
   assign wrIdx    = (pwdata[TB_W-1:0] > TB_W'(TB_LAST)) ? TB_W'(TB_LAST) : pwdata[TB_W-1:0];
   assign oldest   = WAVE_W'(wrPtr_ff - count_ff[WAVE_W-1:0]);
   assign physSel  = WAVE_W'(oldest + sel_ff);

   always_comb
   begin
      rdWord = 32'h0000_0000;
      hit    = 1'b1;
      if (paddr == OFF_STAGE)
      begin
         rdWord = 32'(stage_ff);
      end
      else if (paddr == OFF_ACTIVE)
      begin
         rdWord = 32'(active_ff);
      end
      else if (paddr == OFF_APPLY || paddr == OFF_NAV)
      begin
         rdWord = 32'h0000_0000;
      end
      else if (paddr == OFF_TBASE)
      begin
         rdWord = 32'(tbIdx_ff);
      end
      else if (paddr == OFF_BUFSTAT)
      begin
         rdWord = (32'(sel_ff) << BUF_SEL_LSB) | (32'(count_ff) << BUF_CNT_LSB);
      end
      else if (paddr == OFF_SAMPSEL)
      begin
         rdWord = 32'(sampSel_ff);
      end
      else if (paddr == OFF_SAMPDATA)
      begin
         rdWord = 32'(waveMem[{physSel, sampSel_ff}]);
      end
      else if (paddr == OFF_STATUS)
      begin
         rdWord = {29'h0, contMode, state_ff};
      end
      else
      begin
         hit = 1'b0;
      end
   end

   // answer comes one cycle after setup: the access phase never waits
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff  <= setupPh;
         pslverr_ff <= setupPh & ~hit;
         if (setupPh)
         begin
            prdata_ff <= hit ? rdWord : 32'h0000_0000;
         end
      end
   end

   // ************************************************
   // trigger settings and time base
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stage_ff  <= CFG_RST;
         active_ff <= CFG_RST;
      end
      else if (doCommit)
      begin
         active_ff <= stage_ff;
      end
      else if (doCancel)
      begin
         stage_ff <= active_ff;
      end
      else if (wrAcc && paddr == OFF_STAGE)
      begin
         stage_ff <= cfg_t'(pwdata[$bits(cfg_t)-1:0]);
      end
   end

   // the cycle count is looked up once per write, keeping the wide math off the sample path
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         tbIdx_ff <= TB_RST;
         tbCyc_ff <= tb_cycles(TB_RST);
      end
      else if (wrAcc && paddr == OFF_TBASE)
      begin
         tbIdx_ff <= wrIdx;
         tbCyc_ff <= tb_cycles(wrIdx);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sampSel_ff <= '0;
      end
      else if (wrAcc && paddr == OFF_SAMPSEL)
      begin
         sampSel_ff <= pwdata[REC_W-1:0];
      end
   end

   // ************************************************
   // sample timing
   // ************************************************
   assign contMode   = (tbIdx_ff >= TB_W'(TB_CONT_IDX));
   assign tickDue    = (divCnt_ff >= CYC_W'(tbCyc_ff - 1'b1));
   assign stall      = contMode && (state_ff == ST_CAPT) && !fifoInReady;
   assign sampleTake = tickDue & ~stall;

   // a stalled tick is held, not skipped, so the trace keeps every sample
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         divCnt_ff <= '0;
      end
      else if (sampleTake)
      begin
         divCnt_ff <= '0;
      end
      else if (!tickDue)
      begin
         divCnt_ff <= CYC_W'(divCnt_ff + 1'b1);
      end
   end

   // ************************************************
   // edge detection
   // ************************************************
   assign selLevel = lineLevels[active_ff.chan].level;
   assign above    = (selLevel >= active_ff.thresh);
   always_comb
   begin
      trigHit = 1'b0;
      if (sampleTake && edgeValid_ff)
      begin
         if (active_ff.fall)
         begin
            trigHit = prevAbove_ff & ~above;
         end
         else
         begin
            trigHit = ~prevAbove_ff & above;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b || doCommit)
      begin
         prevAbove_ff <= 1'b0;
         edgeValid_ff <= 1'b0;
      end
      else if (sampleTake)
      begin
         prevAbove_ff <= above;
         edgeValid_ff <= 1'b1;
      end
   end

   // ************************************************
   // auto timeout
   // ************************************************
   assign toExpire = (toCnt_ff == 32'(AUTO_TIMEOUT - 1));

   always_ff @(posedge clk)
   begin
      if (!rst_b || state_ff != ST_ARM || trigHit || doCommit)
      begin
         toCnt_ff <= 32'h0000_0000;
      end
      else if (active_ff.mode == MODE_AUTO && !toExpire)
      begin
         toCnt_ff <= toCnt_ff + 32'h0000_0001;
      end
   end

   // ************************************************
   // capture sequencing
   // ************************************************
   assign capDone = (state_ff == ST_CAPT) && sampleTake
                    && (capIdx_ff == REC_W'(REC_LEN - 1)) && !doCommit;

   always_ff @(posedge clk)
   begin
      if (!rst_b || doCommit)
      begin
         state_ff  <= ST_ARM;
         capIdx_ff <= '0;
      end
      else
      begin
         case (state_ff)
            ST_ARM:
            begin
               capIdx_ff <= '0;
               if (active_ff.mode == MODE_AUTO)
               begin
                  if (trigHit || toExpire)
                  begin
                     state_ff <= ST_CAPT;
                  end
               end
               else if (active_ff.mode == MODE_REPEAT)
               begin
                  if (trigHit)
                  begin
                     state_ff <= ST_CAPT;
                  end
               end
               else
               begin
                  state_ff <= ST_CAPT;
               end
            end
            ST_CAPT:
            begin
               if (sampleTake)
               begin
                  capIdx_ff <= REC_W'(capIdx_ff + 1'b1);
                  if (capIdx_ff == REC_W'(REC_LEN - 1))
                  begin
                     state_ff <= ST_ARM;
                  end
               end
            end
            default:
            begin
               state_ff <= ST_ARM;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (state_ff == ST_CAPT && sampleTake)
      begin
         waveMem[{wrPtr_ff, capIdx_ff}] <= selLevel;
      end
   end

   // ************************************************
   // waveform buffer bookkeeping
   // ************************************************
   // a finished capture moves the display to the newest waveform and beats a step request
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wrPtr_ff <= '0;
         count_ff <= '0;
         sel_ff   <= '0;
      end
      else if (capDone)
      begin
         wrPtr_ff <= WAVE_W'(wrPtr_ff + 1'b1);
         if (count_ff != (WAVE_W+1)'(WAVE_DEPTH))
         begin
            count_ff <= (WAVE_W+1)'(count_ff + 1'b1);
            sel_ff   <= count_ff[WAVE_W-1:0];
         end
         else
         begin
            sel_ff <= WAVE_W'(WAVE_DEPTH - 1);
         end
      end
      else if (doPrev && sel_ff != '0)
      begin
         sel_ff <= WAVE_W'(sel_ff - 1'b1);
      end
      else if (doNext && (WAVE_W+1)'(sel_ff) + 1'b1 < count_ff)
      begin
         sel_ff <= WAVE_W'(sel_ff + 1'b1);
      end
   end

   // ************************************************
   // live trace stream
   // ************************************************
   assign pushWord = '{wave: wrPtr_ff, samp: capIdx_ff, level: selLevel};

   trace_fifo #(
      .W     ($bits(trace_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_b    (rst_b),
      .inValid  (contMode && state_ff == ST_CAPT && sampleTake),
      .inReady  (fifoInReady),
      .inData   (pushWord),
      .outValid (traceValid),
      .outReady (traceReady),
      .outData  (traceData)
   );

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
endmodule : scope_trigger_capture

// File: scope_trigger_capture_checker.sv
// assertions on the ports of the scope trigger and capture block
// assumes the one-cycle APB answer and the register layout of the package
module scope_trigger_capture_checker
   import scope_trigger_pkg::*;
#(
   parameter int AUTO_TIMEOUT = AUTO_TO_CYC
) (
   input wire logic                   clk,
   input wire logic                   rst_b,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire level_t [NUM_LINES-1:0] lineLevels,
   input wire logic                   traceValid,
   input wire logic                   traceReady,
   input wire trace_t                 traceData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   logic [16:0] stageSh_ff;
   logic [16:0] activeSh_ff;
   logic [4:0]  tbSh_ff;
   logic        wrAcc;
   logic        rdAcc;
   assign wrAcc = psel && penable && pready && pwrite;
   assign rdAcc = psel && penable && pready && !pwrite;
   // ************************************************
   // shadows of what software wrote
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         tbSh_ff <= TB_RST;
      else if (wrAcc && paddr == OFF_TBASE)
         tbSh_ff <= (pwdata[4:0] > 5'h1E) ? 5'h1E : pwdata[4:0];
   end
   // commit wins over cancel when both bits are set
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stageSh_ff  <= CFG_RST;
         activeSh_ff <= CFG_RST;
      end
      else if (wrAcc && paddr == OFF_STAGE)
         stageSh_ff <= pwdata[16:0];
      else if (wrAcc && paddr == OFF_APPLY && pwdata[APPLY_COMMIT_BIT])
         activeSh_ff <= stageSh_ff;
      else if (wrAcc && paddr == OFF_APPLY && pwdata[APPLY_CANCEL_BIT])
         stageSh_ff <= activeSh_ff;
   end
   // ************************************************
   // properties
   // ************************************************
   sequence apbSetup;
      psel && !penable;
   endsequence
   ready_follows_a: assert property (apbSetup |=> pready && penable)
      else $error("no answer");
   ready_cause_a: assert property (pready |-> $past(psel && !penable) && psel && penable)
      else $error("stray answer");
   err_unmapped_a: assert property (apbSetup ##0 (paddr > OFF_STATUS || paddr[1:0] != 2'h0)
      |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   err_mapped_a: assert property (apbSetup ##0 (paddr <= OFF_STATUS && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped access refused");
   tbase_read_a: assert property (rdAcc && paddr == OFF_TBASE |-> prdata == {27'h0, tbSh_ff})
      else $error("time base wrong");
   stage_read_a: assert property (rdAcc && paddr == OFF_STAGE |-> prdata == {15'h0, stageSh_ff})
      else $error("stage wrong");
   active_read_a: assert property (rdAcc && paddr == OFF_ACTIVE |-> prdata == {15'h0, activeSh_ff})
      else $error("active wrong");
   buf_range_a: assert property (rdAcc && paddr == OFF_BUFSTAT |-> prdata[13:8] <= 6'h20
      && (prdata[4:0] < prdata[13:8] || prdata[4:0] == 5'h0)) else $error("buffer range");
   status_flags_a: assert property (rdAcc && paddr == OFF_STATUS |-> $onehot(prdata[1:0])
      && prdata[STAT_CONT_BIT] == (int'(tbSh_ff) >= TB_CONT_IDX)) else $error("status flags wrong");
   reset_quiet_a: assert property (rst_b && $past(!rst_b) |-> !pready && !traceValid)
      else $error("busy after reset");
endmodule : scope_trigger_capture_checker

bind scope_trigger_capture scope_trigger_capture_checker #(.AUTO_TIMEOUT(AUTO_TIMEOUT)) chk (.*);

// File: scope_trigger_capture_test.sv
// self-checking testbench of the scope trigger and capture block
// assumes the checker binds itself and the line model drives the samples
module scope_trigger_capture_test
   import scope_trigger_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TO_CYC = 50;
   localparam int LIMIT  = 20000;
   logic                   clk;
   logic                   rst_b;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [11:0]            paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   level_t [NUM_LINES-1:0] lineLevels;
   logic                   traceValid;
   logic                   traceReady;
   trace_t                 traceData;
   logic [31:0]            rdv;
   logic                   errv;
   logic [5:0]             cnt;
   logic [5:0]             base;
   int                     num_errors = 0;
   int                     compares = 0;
   int                     cycles = 0;
   scope_trigger_capture #(.AUTO_TIMEOUT(TO_CYC)) DUT (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lineLevels(lineLevels),
      .traceValid(traceValid), .traceReady(traceReady), .traceData(traceData));
   line_source_model lines (.clk(clk), .lineLevels(lineLevels));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         close_out();
      end
   end
   // ************************************************
   // bus and compare tasks
   // ************************************************
   task automatic close_out();
      $display("mismatches %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   // request held from setup until pready is sampled high
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string name);
      xfer(1'b0, a, 32'h0);
      check(name, exp, rdv);
   endtask : rdChk
   task automatic commit(input logic [31:0] cfg);
      wr(OFF_STAGE, cfg);
      wr(OFF_APPLY, 32'h00000001);
   endtask : commit
   task automatic getCount();
      xfer(1'b0, OFF_BUFSTAT, 32'h0);
      cnt = rdv[13:8];
   endtask : getCount
   task automatic waitCount(input logic [5:0] n, input int polls);
      getCount();
      for (int i = 0; i < polls && cnt !== n; i++)
         getCount();
      check("waveform count", {26'h0, n}, {26'h0, cnt});
   endtask : waitCount
   task automatic holdCount(input int c, input logic [5:0] n);
      repeat (c) @(posedge clk);
      getCount();
      check("unchanged count", {26'h0, n}, {26'h0, cnt});
   endtask : holdCount
   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      rst_b = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      traceReady = 1'b1;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rdChk(OFF_ACTIVE, 32'h00000800, "applied at reset");
      rdChk(OFF_TBASE, 32'h0000000B, "time base at reset");
      xfer(1'b0, 12'h024, 32'h0);
      check("unmapped error", 32'h1, {31'h0, errv});
      wr(OFF_BUFSTAT, 32'hFFFFFFFF);
      check("read-only error", 32'h0, {31'h0, errv});
      wr(OFF_TBASE, 32'h0000001F);
      rdChk(OFF_TBASE, 32'h0000001E, "clamped time base");
      wr(OFF_TBASE, 32'h00000012);
      rdChk(OFF_STATUS, 32'h00000002, "not continuous");
      wr(OFF_TBASE, 32'h00000013);
      rdChk(OFF_STATUS, 32'h00000006, "continuous");
      wr(OFF_TBASE, 32'h00000000);
      waitCount(6'h01, 200);
      wr(OFF_STAGE, 32'h0000F123);
      rdChk(OFF_STAGE, 32'h0000F123, "staged");
      rdChk(OFF_ACTIVE, 32'h00000800, "not yet applied");
      wr(OFF_APPLY, 32'h00000002);
      rdChk(OFF_STAGE, 32'h00000800, "cancelled");
      commit(32'h00014400);
      rdChk(OFF_ACTIVE, 32'h00014400, "applied");
      getCount();
      base = cnt;
      holdCount(300, base);
      lines.setLine(1, 'hF00);
      holdCount(100, base);
      lines.setLine(2, 'h400);
      waitCount(base + 6'h01, 100);
      wr(OFF_SAMPSEL, 32'h00000000);
      rdChk(OFF_SAMPDATA, 32'h00000400, "selected line sample");
      wr(OFF_TBASE, 32'h00000001);
      commit(32'h00015400);
      getCount();
      base = cnt;
      lines.setLine(2, 'h100);
      holdCount(200, base);
      waitCount(base + 6'h01, 100);
      wr(OFF_TBASE, 32'h00000000);
      commit(32'h00008FFF);
      getCount();
      waitCount(cnt + 6'h01, 150);
      lines.setLine(0, 'h123);
      commit(32'h00000000);
      waitCount(6'h20, 2000);
      lines.setLine(0, 'h456);
      repeat (400) @(posedge clk);
      commit(32'h00010FFF);
      rdChk(OFF_BUFSTAT, 32'h0000201F, "full buffer");
      wr(OFF_SAMPSEL, 32'h0000003F);
      rdChk(OFF_SAMPDATA, 32'h00000456, "newest waveform");
      wr(OFF_NAV, 32'h00000002);
      rdChk(OFF_BUFSTAT, 32'h0000201F, "next at newest");
      wr(OFF_NAV, 32'h00000001);
      rdChk(OFF_BUFSTAT, 32'h0000201E, "previous");
      wr(OFF_NAV, 32'h00000002);
      rdChk(OFF_BUFSTAT, 32'h0000201F, "next");
      wr(OFF_NAV, 32'h00000003);
      rdChk(OFF_BUFSTAT, 32'h0000201E, "both steps");
      repeat (31) wr(OFF_NAV, 32'h00000001);
      rdChk(OFF_BUFSTAT, 32'h00002000, "previous at oldest");
      check("trace idle", 32'h0, {31'h0, traceValid});
      close_out();
   end
endmodule : scope_trigger_capture_test

// File: scope_trigger_pkg.sv
// constants, field layouts and carrier types of the scope trigger and capture block
// assumes one 200 MHz clock and software access over APB with 32-bit data
package scope_trigger_pkg;
   // ************************************************
   // geometry
   // ************************************************
   localparam int NUM_LINES  = 4;
   localparam int LINE_W     = 2;
   localparam int LEVEL_W    = 12;
   localparam int WAVE_DEPTH = 32;
   localparam int WAVE_W     = 5;
   localparam int REC_LEN    = 64;
   localparam int REC_W      = 6;
   localparam int FIFO_DEPTH = 8;
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_NS      = 5;
   localparam int DIV_SAMPLES = 10;
   localparam int TB_FAST_NS  = 100;
   localparam int TB_W        = 5;
   localparam int TB_LAST     = 30;
   localparam int TB_CONT_IDX = 19;
   localparam int CYC_W       = 36;
   localparam int AUTO_TO_MS  = 100;
   localparam int AUTO_TO_CYC = AUTO_TO_MS * (1000000 / CLK_NS);
   // ************************************************
   // register map and fields
   // ************************************************
   localparam logic [11:0] OFF_STAGE    = 12'h000;
   localparam logic [11:0] OFF_APPLY    = 12'h004;
   localparam logic [11:0] OFF_ACTIVE   = 12'h008;
   localparam logic [11:0] OFF_TBASE    = 12'h00C;
   localparam logic [11:0] OFF_NAV      = 12'h010;
   localparam logic [11:0] OFF_BUFSTAT  = 12'h014;
   localparam logic [11:0] OFF_SAMPSEL  = 12'h018;
   localparam logic [11:0] OFF_SAMPDATA = 12'h01C;
   localparam logic [11:0] OFF_STATUS   = 12'h020;
   localparam int APPLY_COMMIT_BIT = 0;
   localparam int APPLY_CANCEL_BIT = 1;
   localparam int NAV_PREV_BIT     = 0;
   localparam int NAV_NEXT_BIT     = 1;
   localparam int BUF_SEL_LSB      = 0;
   localparam int BUF_CNT_LSB      = 8;
   localparam int STAT_CONT_BIT    = 2;
   localparam logic [TB_W-1:0] TB_RST = 5'h0B;
   typedef enum logic [1:0] {MODE_NONE = 2'h0, MODE_AUTO = 2'h1, MODE_REPEAT = 2'h2} trig_mode_t;
   typedef enum logic [1:0] {ST_ARM = 2'b01, ST_CAPT = 2'b10} cap_state_t;
   typedef struct packed {
      logic [LEVEL_W-1:0] level;
   } level_t;
   typedef struct packed {
      logic [1:0]         mode;
      logic [LINE_W-1:0]  chan;
      logic               fall;
      logic [LEVEL_W-1:0] thresh;
   } cfg_t;
   localparam cfg_t CFG_RST = '{mode: MODE_NONE, chan: 2'h0, fall: 1'b0, thresh: 12'h800};
   typedef struct packed {
      logic [WAVE_W-1:0]  wave;
      logic [REC_W-1:0]   samp;
      logic [LEVEL_W-1:0] level;
   } trace_t;
   // cycles between samples for a 1-2-5 time base index
   function automatic logic [CYC_W-1:0] tb_cycles(input logic [TB_W-1:0] idx);
      longint ns;
      int     dec;
      ns  = TB_FAST_NS;
      dec = idx / 3;
      for (int i = 0; i < 11; i++)
      begin
         if (i < dec)
         begin
            ns = ns * 10;
         end
      end
      if (idx % 3 == 1)
      begin
         ns = ns * 2;
      end
      else if (idx % 3 == 2)
      begin
         ns = ns * 5;
      end
      return CYC_W'(ns / (DIV_SAMPLES * CLK_NS));
   endfunction : tb_cycles
endpackage : scope_trigger_pkg
